// ---- rtl/pcr_config_regs.sv ----
/*
  Pad and resync configuration register bank: five 8-bit registers reached
  over Avalon-MM, driving pad pull-down and drive enables, the gain scaler
  bypass and a datapath resync pulse.
  Assumes one clock, synchronous inputs and a master that holds its request
  until waitrequest is low.
*/
// Behaviour
// - Bit 6 of register 0x58 set makes the delta-sigma path bypass the gain scaler.
// - Bit 1 of register 0x58 enables the SPI data-out pad pull-down.
// - Bit 0 of register 0x58 selects strong drive on the SPI data-out pad.
// - Register 0x59 bit 1 audio-out pull-down, bit 0 audio-out strong drive.
// - Register 0x5A bit 1 master clock pull-down, bit 0 its strong drive.
// - Register 0x5B bit 1 bit clock pull-down, bit 0 its strong drive.
// - Register 0x5C bit 1 frame sync pull-down, bit 0 its strong drive.
// - Writing bit 7 of 0x5C to 1 then 0 resyncs the datapath.
// - Resync acts only in external sampling or audio output mode.
// - All five registers reset to zero; reserved bits read zero, ignore writes.
`timescale 1ns/1ns
`include "pcr_defines.svh"

module pcr_config_regs
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     arst_n_in,
  // avalon-mm slave
  input  wire logic [`PCR_ADDR_W-1:0]   avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [`PCR_DATA_W-1:0]   avs_writedata_in,
  input  wire logic [3:0]               avs_byteenable_in,
  output logic      [`PCR_DATA_W-1:0]   avs_readdata_out,
  output logic                          avs_waitrequest_out,
  output logic [1:0]                    avs_response_out,
  // operating mode
  input  wire logic                     external_sampling_mode_in,
  input  wire logic                     audio_mode_in,
  // datapath controls
  output logic                          gain_scaler_bypass_out,
  output logic                          datapath_resync_out,
  // pad controls
  output logic                          spi_out_pulldown_en_out,
  output logic                          spi_out_strong_drive_out,
  output logic                          audio_out_pulldown_en_out,
  output logic                          audio_out_strong_drive_out,
  output logic                          master_clock_pulldown_en_out,
  output logic                          master_clock_strong_drive_out,
  output logic                          bit_clock_pulldown_en_out,
  output logic                          bit_clock_strong_drive_out,
  output logic                          frame_sync_pulldown_en_out,
  output logic                          frame_sync_strong_drive_out
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  localparam logic [7:0] OFS [`PCR_NUM_REGS] = '{
    `PCR_OFS_SPI_OUT, `PCR_OFS_AUDIO_OUT, `PCR_OFS_MASTER_CLK, `PCR_OFS_BIT_CLK, `PCR_OFS_FRAME_SYNC
  };
  localparam logic [7:0] MSK [`PCR_NUM_REGS] = '{
    `PCR_MASK_SPI_OUT, `PCR_MASK_PAD, `PCR_MASK_PAD, `PCR_MASK_PAD, `PCR_MASK_FRAME_SYNC
  };

  logic [`PCR_NUM_REGS-1:0] hit;
  logic [7:0]               reg_val [`PCR_NUM_REGS];
  logic                     any_hit;
  logic                     ack_q;
  logic                     req;
  logic                     wr_fire;
  logic [7:0]               rd_mux;

  assign req     = avs_read_in | avs_write_in;
  // the answer is one cycle late so read data can come from a flop
  assign wr_fire = avs_write_in & !ack_q & avs_byteenable_in[0];
  assign any_hit = |hit;

  // ------------------------------------------------------------
  // register array
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PCR_NUM_REGS; gi = gi + 1) begin : g_reg
      assign hit[gi] = (avs_address_in == OFS[gi]);
      pcr_pad_reg #(
        .WR_MASK (MSK[gi])
      ) u_reg (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .wr_en_in   (wr_fire & hit[gi]),
        .wr_data_in (avs_writedata_in[7:0]),
        .value_out  (reg_val[gi])
      );
    end
  endgenerate

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < `PCR_NUM_REGS; i++) begin
      if (hit[i]) begin
        rd_mux = reg_val[i];
      end
    end
  end

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // ack_q high for exactly one cycle per request
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & !ack_q;
    end
  end

  assign avs_waitrequest_out = !ack_q;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= 2'h0;
    end else if (req & !ack_q) begin
      avs_readdata_out <= {24'h00_0000, (avs_read_in ? rd_mux : 8'h00)};
      // unmapped addresses answer with a decode error, reads give zero
      avs_response_out <= any_hit ? 2'h0 : 2'h3;
    end
  end

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  assign gain_scaler_bypass_out        = reg_val[0][`PCR_BIT_BYPASS];
  // pad enables are plain flop outputs, live from the write edge
  assign spi_out_pulldown_en_out       = reg_val[0][`PCR_BIT_PD];
  assign spi_out_strong_drive_out      = reg_val[0][`PCR_BIT_DRV];
  assign audio_out_pulldown_en_out     = reg_val[1][`PCR_BIT_PD];
  assign audio_out_strong_drive_out    = reg_val[1][`PCR_BIT_DRV];
  assign master_clock_pulldown_en_out  = reg_val[2][`PCR_BIT_PD];
  assign master_clock_strong_drive_out = reg_val[2][`PCR_BIT_DRV];
  assign bit_clock_pulldown_en_out     = reg_val[3][`PCR_BIT_PD];
  assign bit_clock_strong_drive_out    = reg_val[3][`PCR_BIT_DRV];
  assign frame_sync_pulldown_en_out    = reg_val[4][`PCR_BIT_PD];
  assign frame_sync_strong_drive_out   = reg_val[4][`PCR_BIT_DRV];

  // ------------------------------------------------------------
  // datapath resync
  // ------------------------------------------------------------
  // mode is sampled when the bit returns to 0, not when it is set
  pcr_resync_seq u_resync (
    .ref_clk_in                (ref_clk_in),
    .arst_n_in                 (arst_n_in),
    .resync_bit_in             (reg_val[4][`PCR_BIT_RESYNC]),
    .external_sampling_mode_in (external_sampling_mode_in),
    .audio_mode_in             (audio_mode_in),
    .resync_pulse_out          (datapath_resync_out)
  );

endmodule

// ---- rtl/pcr_defines.svh ----
/*
  Register offsets, field positions, masks and reset values of the pad and resync
  configuration bank. Assumes inclusion by bare name from the rtl folder.
*/
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

`define PCR_ADDR_W          8
`define PCR_DATA_W          32
`define PCR_REG_W           8
`define PCR_OFS_SPI_OUT     8'h58
`define PCR_OFS_AUDIO_OUT   8'h59
`define PCR_OFS_MASTER_CLK  8'h5A
`define PCR_OFS_BIT_CLK     8'h5B
`define PCR_OFS_FRAME_SYNC  8'h5C
`define PCR_NUM_REGS        5
`define PCR_RESET_VAL       8'h00
`define PCR_BIT_DRV         0
`define PCR_BIT_PD          1
`define PCR_BIT_BYPASS      6
`define PCR_BIT_RESYNC      7
`define PCR_MASK_PAD        8'h03
`define PCR_MASK_SPI_OUT    8'h43
`define PCR_MASK_FRAME_SYNC 8'h83
`define PCR_RD_LATENCY      1

`endif

// ---- rtl/pcr_pad_reg.sv ----
/*
  One 8-bit configuration register with a writable-bit mask.
  Assumes write strobe and data arrive synchronous to ref_clk_in.
*/
`timescale 1ns/1ns
`include "pcr_defines.svh"

module pcr_pad_reg
  import pcr_pkg::*;
#(
  parameter logic [7:0] WR_MASK = `PCR_MASK_PAD
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  // write port
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_data_in,
  // stored value
  output logic      [7:0] value_out
);

  logic [7:0] value_q;

  // reserved bits never store, so they read zero
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      value_q <= `PCR_RESET_VAL;
    end else if (wr_en_in) begin
      value_q <= wr_data_in & WR_MASK;
    end
  end

  assign value_out = value_q;

endmodule

// ---- rtl/pcr_pkg.sv ----
/*
  Types shared by the pad and resync configuration bank.
  Assumes pcr_defines.svh is compiled alongside.
*/
package pcr_pkg;
  typedef enum logic [1:0] {
    PCR_IDLE  = 2'b00,
    PCR_ARMED = 2'b01,
    PCR_FIRE  = 2'b11
  } pcr_resync_st_t;
endpackage

// ---- rtl/pcr_resync_seq.sv ----
/*
  Watches the resync control bit for a 1-then-0 sequence and issues a
  one-cycle datapath resync pulse when the mode allows it.
  Assumes mode inputs are synchronous to ref_clk_in.
*/
`timescale 1ns/1ns
`include "pcr_defines.svh"

module pcr_resync_seq
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // control
  input  wire logic resync_bit_in,
  input  wire logic external_sampling_mode_in,
  input  wire logic audio_mode_in,
  // result
  output logic      resync_pulse_out
);

  pcr_resync_st_t state_q;
  pcr_resync_st_t state_d;
  logic           mode_ok;

  assign mode_ok = external_sampling_mode_in | audio_mode_in;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PCR_IDLE: begin
        if (resync_bit_in) begin
          state_d = PCR_ARMED;
        end
      end
      PCR_ARMED: begin
        // falling back to 0 completes the request
        if (!resync_bit_in) begin
          state_d = mode_ok ? PCR_FIRE : PCR_IDLE;
        end
      end
      PCR_FIRE: begin
        state_d = resync_bit_in ? PCR_ARMED : PCR_IDLE;
      end
      default: begin
        state_d = PCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= PCR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // one-cycle pulse from a register, never combinational
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      resync_pulse_out <= 1'b0;
    end else begin
      resync_pulse_out <= (state_d == PCR_FIRE);
    end
  end

endmodule

// ---- testbench/pcr_config_regs_chk.sv ----
/* Assertion checker for the pad and resync register bank.
   Assumes the one-wait-cycle Avalon answer of the bank and binds to its top. */
`timescale 1ns/1ns
`include "pcr_defines.svh"

module pcr_config_regs_chk (
  // watched ports
  input wire logic                   ref_clk_in,
  input wire logic                   arst_n_in,
  input wire logic [`PCR_ADDR_W-1:0] avs_address_in,
  input wire logic                   avs_read_in,
  input wire logic                   avs_write_in,
  input wire logic [`PCR_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0]             avs_byteenable_in,
  input wire logic [`PCR_DATA_W-1:0] avs_readdata_out,
  input wire logic                   avs_waitrequest_out,
  input wire logic [1:0]             avs_response_out,
  input wire logic                   external_sampling_mode_in,
  input wire logic                   audio_mode_in,
  input wire logic                   gain_scaler_bypass_out,
  input wire logic                   datapath_resync_out,
  input wire logic                   master_clock_pulldown_en_out,
  input wire logic                   master_clock_strong_drive_out,
  input wire logic                   frame_sync_pulldown_en_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic       ack;
  logic       unmap;
  logic [7:0] rsv_mask;
  assign ack   = !avs_waitrequest_out;
  // reserved bits of whichever register is addressed
  assign rsv_mask = ~((avs_address_in == `PCR_OFS_SPI_OUT) ? `PCR_MASK_SPI_OUT :
                      (avs_address_in == `PCR_OFS_FRAME_SYNC) ? `PCR_MASK_FRAME_SYNC : `PCR_MASK_PAD);
  assign unmap = (avs_address_in < 8'h58) || (avs_address_in > 8'h5C);

  // ---------------------------------------------------------------
  // bus answer and register contents
  // ---------------------------------------------------------------
  a_answer_one_wait: assert property ((avs_read_in || avs_write_in) && !ack |=> ack)
    else $error("request not answered after one wait cycle");
  a_answer_one_cycle: assert property (ack |=> !ack)
    else $error("answer stood longer than one cycle");
  a_unmapped_error: assert property (ack && unmap |-> avs_response_out == 2'h3 && avs_readdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_reserved_reads_zero: assert property (ack && avs_read_in |->
    avs_readdata_out[31:8] == 24'h0 && (avs_readdata_out[7:0] & rsv_mask) == 8'h00)
    else $error("reserved bits read nonzero");
  a_pad_follow_write: assert property (ack && avs_write_in && avs_address_in == 8'h5A && avs_byteenable_in[0] |->
    master_clock_pulldown_en_out == avs_writedata_in[1] && master_clock_strong_drive_out == avs_writedata_in[0])
    else $error("clock pad controls do not follow write");
  a_bypass_follow: assert property (ack && avs_write_in && avs_address_in == 8'h58 && avs_byteenable_in[0] |->
    gain_scaler_bypass_out == avs_writedata_in[6])
    else $error("gain bypass does not follow write");
  a_pads_hold_idle: assert property (!avs_write_in |=> $stable(frame_sync_pulldown_en_out) && $stable(gain_scaler_bypass_out))
    else $error("control changed without a write");

  // ---------------------------------------------------------------
  // resync pulse
  // ---------------------------------------------------------------
  a_resync_cause: assert property (datapath_resync_out |-> $past(avs_write_in && avs_address_in == 8'h5C &&
    !avs_writedata_in[7] && (external_sampling_mode_in || audio_mode_in), 2))
    else $error("resync pulse without clearing write in a valid mode");
  a_resync_single: assert property (datapath_resync_out |=> !datapath_resync_out)
    else $error("resync pulse longer than one cycle");
endmodule

bind pcr_config_regs pcr_config_regs_chk pcr_config_regs_chk_inst (.ref_clk_in, .arst_n_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .avs_response_out, .external_sampling_mode_in, .audio_mode_in, .gain_scaler_bypass_out, .datapath_resync_out,
  .master_clock_pulldown_en_out, .master_clock_strong_drive_out, .frame_sync_pulldown_en_out);

// ---- testbench/tb.sv ----
/* Self-checking bench for the pad and resync register bank.
   Assumes the bank answers every Avalon request after one wait cycle. */
`timescale 1ns/1ns

module tb;
  logic        ref_clk_in, arst_n_in, avs_read_in, avs_write_in, external_sampling_mode_in, audio_mode_in;
  logic [7:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
  logic [3:0]  avs_byteenable_in;
  logic [1:0]  avs_response_out, resp;
  logic        avs_waitrequest_out, gain_scaler_bypass_out, datapath_resync_out;
  logic        spi_out_pulldown_en_out, spi_out_strong_drive_out, audio_out_pulldown_en_out;
  logic        audio_out_strong_drive_out, master_clock_pulldown_en_out, master_clock_strong_drive_out;
  logic        bit_clock_pulldown_en_out, bit_clock_strong_drive_out, frame_sync_pulldown_en_out;
  logic        frame_sync_strong_drive_out;
  logic [9:0]  pads;
  logic [7:0]  mask [5] = '{8'h43, 8'h03, 8'h03, 8'h03, 8'h83};
  int          n_errors = 0, n_checks = 0, n_pulse = 0, p;

  pcr_config_regs pcr_config_regs_inst (.*);

  assign pads = {spi_out_pulldown_en_out, spi_out_strong_drive_out, audio_out_pulldown_en_out,
                 audio_out_strong_drive_out, master_clock_pulldown_en_out, master_clock_strong_drive_out,
                 bit_clock_pulldown_en_out, bit_clock_strong_drive_out, frame_sync_pulldown_en_out,
                 frame_sync_strong_drive_out};

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) if (datapath_resync_out === 1'b1) n_pulse <= n_pulse + 1;

  // ---------------------------------------------------------------
  // bus, check and report tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int i;
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    i = 0;
    do begin
      @(posedge ref_clk_in);
      i++;
    end while (avs_waitrequest_out !== 1'b0 && i < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      n_errors++;
      conclude();
    end
    rdata = avs_readdata_out;
    resp = avs_response_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {arst_n_in, avs_read_in, avs_write_in, external_sampling_mode_in, audio_mode_in} <= 5'h00;
    {avs_address_in, avs_writedata_in, avs_byteenable_in} <= 44'h0;
    repeat (2) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, 8'h58 + 8'(k), 32'h0, 4'hF);
      chk(rdata, 32'h0);
      chk({30'h0, resp}, 32'h0);
    end
    chk({22'h0, pads}, 32'h0);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b0, 8'h58 + 8'(k), 32'hFFFFFFFF, 4'hF);
      xfer(1'b1, 8'h58 + 8'(k), 32'h0, 4'hF);
      chk(rdata, {24'h0, mask[k]});
    end
    chk({21'h0, gain_scaler_bypass_out, pads}, 32'h7FF);
    // clearing 0x5C bit 7 here with both modes low must not resync
    for (int k = 0; k < 5; k++) xfer(1'b0, 8'h58 + 8'(k), 32'h2, 4'hF);
    repeat (3) @(posedge ref_clk_in);
    chk({21'h0, gain_scaler_bypass_out, pads}, 32'h2AA);
    chk(32'(n_pulse), 32'h0);
    xfer(1'b0, 8'h5B, 32'h1, 4'h0);
    xfer(1'b1, 8'h5B, 32'h0, 4'hF);
    chk(rdata, 32'h2);
    xfer(1'b1, 8'h5D, 32'h0, 4'hF);
    chk({30'h0, resp}, 32'h3);
    chk(rdata, 32'h0);
    for (int m = 0; m < 4; m++) begin
      external_sampling_mode_in <= m[0];
      audio_mode_in <= m[1];
      p = n_pulse;
      xfer(1'b0, 8'h5C, 32'h80, 4'hF);
      xfer(1'b0, 8'h5C, 32'h00, 4'hF);
      repeat (3) @(posedge ref_clk_in);
      chk(32'(n_pulse - p), {31'h0, m != 0});
    end
    xfer(1'b0, 8'h58, 32'h43, 4'hF);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    xfer(1'b1, 8'h58, 32'h0, 4'hF);
    chk(rdata, 32'h0);
    chk({21'h0, gain_scaler_bypass_out, pads}, 32'h0);
    conclude();
  end
endmodule
